// >>> hw/bil_crc_byte.sv
/*
  Byte-wide reflected CRC-32 step used by the loader.
  Assumes the caller holds the running register and presets it.
*/
`timescale 1ns/1ps
`default_nettype none
module bil_crc_byte
(
  input  wire logic [31:0] crc_i,
  input  wire logic [7:0]  data_i,
  output logic      [31:0] crc_o
);

  // Eight reflected shift steps, least significant bit of data first.
  always_comb
  begin
    logic [31:0] c;
    c = crc_i ^ {24'h000000, data_i};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ bil_pkg::CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end

endmodule : bil_crc_byte
`default_nettype wire

// >>> hw/bil_loader.sv
/*
  Boot image loader for one tile: reset phase, boot source choice and a quad
  serial flash master that reads, checks and stores the image.
  Assumes flash data pins are returned asynchronously and straps are stable
  across reset release. Other boot paths are only reported, not run.
*/
// Operation
// - While reset is low, stay in reset and pull down all pins.
// - After release, wait an internal reset phase of 15-150 us before booting.
// - Security bit 5 set forces boot from OTP, ignoring straps.
// - Straps 000..011 pick QSPI, SPI master, SPI slave, slave-both; no link.
// - Strap 100 boots both tiles over channel end 0, link zero 2-wire.
// - Image is length in words, length*4 bytes, then a check word.
// - Check word 0x0D15AB1E skips CRC verification.
// - Length and check word are least significant byte first.
// - Program goes to lowest RAM address; execution starts there.
// - CRC covers length word and program bytes, not the check word.
// - CRC is reflected 0xEDB88320, preset all ones, result inverted.
// - Quad boot drives select, clock, four data; sclk is core/8.
// - Open with read command and 24-bit address zero.
// - Serial clock polarity 0 and phase 0.
// - Each byte arrives as two nibbles, low nibble first.
// - Quad boot pins are fixed; other pins only via OTP program.
`timescale 1ns/1ps
`default_nettype none
module bil_loader
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 boot_select_bit0_i,
  input  wire logic                 boot_select_bit1_i,
  input  wire logic                 boot_select_bit2_i,
  input  wire logic [31:0]          security_reg_i,
  input  wire logic [3:0]           quad_data_lines_i,
  output bil_pkg::bil_qpins_t       qpins_o,
  output logic                      pull_down_en_o,
  output bil_pkg::bil_ram_wr_t      ram_wr_o,
  output logic                      run_o,
  output bil_pkg::bil_status_t      status_o
);

  typedef enum logic [3:0] {
    ST_RESET  = 4'b0000,
    ST_SELECT = 4'b0001,
    ST_CMD    = 4'b0010,
    ST_LEN    = 4'b0011,
    ST_DATA   = 4'b0100,
    ST_CHECK  = 4'b0101,
    ST_VERIFY = 4'b0110,
    ST_RUN    = 4'b0111,
    ST_FAIL   = 4'b1000,
    ST_OTHER  = 4'b1001
  } bil_state_t;

  localparam int unsigned RAM_AW_L = bil_pkg::RAM_AW;

  bil_state_t        state;
  logic [31:0]       phase_cnt;
  logic [2:0]        strap_meta;
  logic [2:0]        strap;
  logic              secure;
  logic [3:0]        q_meta;
  logic [3:0]        q_sync;
  logic [2:0]        div_cnt;
  logic              sclk;
  logic              rise_en;
  logic              fall_en;
  logic [31:0]       shreg;
  logic [5:0]        bit_cnt;
  logic              nib_hi;
  logic [3:0]        nib_lo;
  logic [31:0]       word_sr;
  logic [1:0]        byte_cnt;
  logic [31:0]       words_left;
  logic [RAM_AW_L-1:0] wr_addr;
  logic [31:0]       crc;
  logic [31:0]       next_crc;
  logic [7:0]        rx_byte;
  logic              byte_en;

  // Straps are pins, so they pass a metastability flop before the capture stage reads them.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strap_meta <= 3'h0;
      strap      <= 3'h0;
      secure     <= 1'b0;
    end
    else
    begin
      strap_meta <= {boot_select_bit2_i, boot_select_bit1_i, boot_select_bit0_i};
      if (state == ST_RESET)
      begin
        strap  <= strap_meta;
        secure <= security_reg_i[bil_pkg::SEC_SECURE_BOOT_BIT];
      end
    end
  end

  // Flash data lines are off-domain; two flops before use.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q_meta <= 4'h0;
      q_sync <= 4'h0;
    end
    else
    begin
      q_meta <= quad_data_lines_i;
      q_sync <= q_meta;
    end
  end

  // Serial clock divider; idles low between transfers.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_cnt <= 3'h0;
      sclk    <= 1'b0;
    end
    else if (state == ST_CMD || state == ST_LEN || state == ST_DATA || state == ST_CHECK)
    begin
      div_cnt <= div_cnt + 3'h1;
      if (div_cnt == 3'(bil_pkg::SCLK_HALF - 1) || div_cnt == 3'(bil_pkg::SCLK_DIV - 1))
        sclk <= ~sclk;
    end
    else
    begin
      div_cnt <= 3'h0;
      sclk    <= 1'b0;
    end
  end

  // Sample on rising edge, shift out on falling edge: mode 0.
  assign rise_en = (div_cnt == 3'(bil_pkg::SCLK_HALF - 1)) && !sclk;
  assign fall_en = (div_cnt == 3'(bil_pkg::SCLK_DIV - 1)) && sclk;

  bil_crc_byte u_crc
  (
    .crc_i  (crc),
    .data_i (rx_byte),
    .crc_o  (next_crc)
  );

  // Low nibble first, then high nibble completes the byte.
  assign rx_byte = {q_sync, nib_lo};
  assign byte_en = rise_en && nib_hi && (state != ST_CMD);

  // Main sequencer and data path.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state      <= ST_RESET;
      phase_cnt  <= 32'h0;
      shreg      <= 32'h0;
      bit_cnt    <= 6'h0;
      nib_hi     <= 1'b0;
      nib_lo     <= 4'h0;
      word_sr    <= 32'h0;
      byte_cnt   <= 2'h0;
      words_left <= 32'h0;
      wr_addr    <= bil_pkg::RAM_BASE;
      crc        <= bil_pkg::CRC_PRESET;
      ram_wr_o   <= '0;
      run_o      <= 1'b0;
      status_o   <= '0;
      qpins_o    <= '{sel_b: 1'b1, sclk: 1'b0, dout: 4'h0, doe: 4'h0};
      pull_down_en_o <= 1'b1;
    end
    else
    begin
      ram_wr_o.we  <= 1'b0;
      // The pin clock moves on the divider edges themselves, so data never changes while it is high.
      qpins_o.sclk <= rise_en ? 1'b1 : (fall_en ? 1'b0 : qpins_o.sclk);
      case (state)
        ST_RESET:
        begin
          phase_cnt <= phase_cnt + 32'h1;
          if (phase_cnt == 32'(bil_pkg::RESET_PHASE_CYC - 1))
            state <= ST_SELECT;
        end
        ST_SELECT:
        begin
          pull_down_en_o <= 1'b0;
          status_o.link_zero_en <= 1'b0;
          if (secure)
          begin
            status_o.tile0_src <= bil_pkg::BIL_SRC_OTP;
            status_o.tile1_src <= bil_pkg::BIL_SRC_OTP;
            state <= ST_OTHER;
          end
          else
          begin
            status_o.tile1_src <= bil_pkg::BIL_SRC_CHAN;
            state <= ST_OTHER;
            case (strap)
              bil_pkg::BOOT_QSPI_MASTER:
              begin
                status_o.tile0_src <= bil_pkg::BIL_SRC_QSPI;
                shreg   <= {bil_pkg::FLASH_READ_CMD, bil_pkg::FLASH_START_ADDR};
                bit_cnt <= 6'h0;
                qpins_o.sel_b <= 1'b0;
                qpins_o.doe   <= 4'h1;
                qpins_o.dout  <= {3'h0, bil_pkg::FLASH_READ_CMD[7]};
                state <= ST_CMD;
              end
              bil_pkg::BOOT_SPI_MASTER:
                status_o.tile0_src <= bil_pkg::BIL_SRC_SPIM;
              bil_pkg::BOOT_SPI_SLAVE:
                status_o.tile0_src <= bil_pkg::BIL_SRC_SPIS;
              bil_pkg::BOOT_SPI_SLAVE_ALL:
              begin
                status_o.tile0_src <= bil_pkg::BIL_SRC_SPIS;
                status_o.tile1_src <= bil_pkg::BIL_SRC_SPIS;
              end
              bil_pkg::BOOT_LINK:
              begin
                status_o.tile0_src    <= bil_pkg::BIL_SRC_CHAN;
                status_o.link_zero_en <= 1'b1;
              end
              default:
                status_o.tile0_src <= bil_pkg::BIL_SRC_CHAN;
            endcase
          end
        end
        ST_CMD:
        begin
          // Command and address go out one bit per clock on line 0.
          if (fall_en)
          begin
            shreg        <= {shreg[30:0], 1'b0};
            qpins_o.dout <= {3'h0, shreg[30]};
            bit_cnt      <= bit_cnt + 6'h1;
            if (bit_cnt == bil_pkg::HDR_BITS - 6'h1)
            begin
              qpins_o.doe <= 4'h0;
              nib_hi      <= 1'b0;
              byte_cnt    <= 2'h0;
              state       <= ST_LEN;
            end
          end
        end
        ST_LEN, ST_DATA, ST_CHECK:
        begin
          if (rise_en)
          begin
            nib_hi <= ~nib_hi;
            if (!nib_hi)
              nib_lo <= q_sync;
          end
          if (byte_en)
          begin
            // Bytes assemble least significant first.
            word_sr  <= {rx_byte, word_sr[31:8]};
            byte_cnt <= byte_cnt + 2'h1;
            if (state != ST_CHECK)
              crc <= next_crc;
            if (byte_cnt == 2'h3)
            begin
              case (state)
                ST_LEN:
                begin
                  words_left <= {rx_byte, word_sr[31:8]};
                  state <= ({rx_byte, word_sr[31:8]} == 32'h0) ? ST_CHECK : ST_DATA;
                end
                ST_DATA:
                begin
                  ram_wr_o.we   <= 1'b1;
                  ram_wr_o.addr <= wr_addr;
                  ram_wr_o.data <= {rx_byte, word_sr[31:8]};
                  wr_addr       <= wr_addr + 14'h0001;
                  words_left    <= words_left - 32'h1;
                  if (words_left == 32'h1)
                    state <= ST_CHECK;
                end
                default:
                begin
                  word_sr       <= {rx_byte, word_sr[31:8]};
                  qpins_o.sel_b <= 1'b1;
                  qpins_o.sclk  <= 1'b0;  // No clock rise may go out as select lifts
                  state         <= ST_VERIFY;
                end
              endcase
            end
          end
        end
        ST_VERIFY:
        begin
          // Skip value bypasses the check; otherwise compare inverted residue.
          if (word_sr == bil_pkg::NO_CRC_WORD || word_sr == ~crc)
            state <= ST_RUN;
          else
            state <= ST_FAIL;
        end
        ST_RUN:
        begin
          run_o         <= 1'b1;
          status_o.done <= 1'b1;
        end
        ST_FAIL:
        begin
          status_o.fail <= 1'b1;
          status_o.done <= 1'b1;
        end
        ST_OTHER:
          status_o.done <= 1'b1;
        default:
          state <= ST_RESET;
      endcase
    end
  end

endmodule : bil_loader
`default_nettype wire

// >>> shared/bil_pkg.sv
/*
  Package for the boot image loader: boot source encodings, image constants,
  timing counts and the packed structs that carry grouped signals.
  Assumes a 100 MHz core clock feeding the loader.
*/
`default_nettype none
package bil_pkg;

  // Core clock figures.
  localparam int unsigned CLK_MHZ           = 100;
  // Internal reset phase, chosen inside the documented 15-150 us window.
  localparam int unsigned RESET_PHASE_US    = 20;
  localparam int unsigned RESET_PHASE_CYC   = RESET_PHASE_US * CLK_MHZ;
  // Serial clock is core/8: 50 MHz at a 400 MHz core, 12.5 MHz at 100 MHz.
  localparam int unsigned SCLK_DIV          = 8;
  localparam int unsigned SCLK_HALF         = SCLK_DIV / 2;

  // Strap pattern field positions and values.
  localparam logic [2:0] BOOT_QSPI_MASTER   = 3'h0;
  localparam logic [2:0] BOOT_SPI_MASTER    = 3'h1;
  localparam logic [2:0] BOOT_SPI_SLAVE     = 3'h2;
  localparam logic [2:0] BOOT_SPI_SLAVE_ALL = 3'h3;
  localparam logic [2:0] BOOT_LINK          = 3'h4;
  localparam int unsigned SEC_SECURE_BOOT_BIT = 5;

  // Flash read command and start address.
  localparam logic [7:0]  FLASH_READ_CMD    = 8'h03;
  localparam logic [23:0] FLASH_START_ADDR  = 24'h000000;
  localparam logic [31:0] NO_CRC_WORD       = 32'h0D15AB1E;
  localparam logic [31:0] CRC_POLY          = 32'hEDB88320;
  localparam logic [31:0] CRC_PRESET        = 32'hFFFFFFFF;

  localparam int unsigned RAM_AW            = 14;
  localparam logic [RAM_AW-1:0] RAM_BASE    = 14'h0000;
  localparam logic [5:0]  HDR_BITS          = 6'h20;

  // Selected boot path.
  typedef enum logic [2:0] {
    BIL_SRC_QSPI   = 3'b000,
    BIL_SRC_SPIM   = 3'b001,
    BIL_SRC_SPIS   = 3'b010,
    BIL_SRC_CHAN   = 3'b011,
    BIL_SRC_OTP    = 3'b100
  } bil_src_t;

  // Outcome reported to the rest of the tile.
  typedef struct packed {
    logic     done;
    logic     fail;
    bil_src_t tile0_src;
    bil_src_t tile1_src;
    logic     link_zero_en;
  } bil_status_t;

  // One RAM write.
  typedef struct packed {
    logic              we;
    logic [RAM_AW-1:0] addr;
    logic [31:0]       data;
  } bil_ram_wr_t;

  // Quad pin drive: select, clock, data out and enables.
  typedef struct packed {
    logic       sel_b;
    logic       sclk;
    logic [3:0] dout;
    logic [3:0] doe;
  } bil_qpins_t;

endpackage : bil_pkg
`default_nettype wire

// >>> test/bil_flash_model.sv
/*
  Behavioural quad serial flash holding one boot image in mem.
  Assumes the bench resolves the shared data lines and loads mem.
*/
`timescale 1ns/1ps
`default_nettype none
module bil_flash_model
(
  input  wire logic        sel_b_i,
  input  wire logic        sclk_i,
  input  wire logic [3:0]  line_i,
  output logic      [3:0]  data_o,
  output logic      [31:0] cmd_o
);
  logic [7:0] mem [0:63];
  int         rises = 0;
  int         nib = 0;
  initial data_o = 4'h0;
  initial cmd_o = 32'h0;
  // A new frame restarts the command and nibble counts.
  always @(negedge sel_b_i)
  begin
    rises = 0;
    nib = 0;
  end
  // Command bits are taken on the rising serial clock edge.
  always @(posedge sclk_i)
  begin
    if (!sel_b_i && rises < 32)
      cmd_o = {cmd_o[30:0], line_i[0]};
    if (!sel_b_i)
      rises = rises + 1;
  end
  // Nibbles change on the falling edge so each stands a whole clock; deselecting flips the lines once.
  always @(negedge sclk_i or posedge sel_b_i)
  begin
    if (sel_b_i)
      data_o <= ~data_o;
    else if (rises >= 32)
    begin
      data_o <= nib[0] ? mem[nib >> 1][7:4] : mem[nib >> 1][3:0];
      nib = nib + 1;
    end
  end
endmodule : bil_flash_model
`default_nettype wire

// >>> test/bil_loader_sva.sv
/*
  Port checker for the boot image loader.
  Assumes it is bound to the loader top and clocked by the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bil_loader_sva
(
  input wire logic                 ref_clk_i,
  input wire logic                 rst_b_i,
  input wire bil_pkg::bil_qpins_t  qpins_o,
  input wire logic                 pull_down_en_o,
  input wire bil_pkg::bil_ram_wr_t ram_wr_o,
  input wire logic                 run_o,
  input wire bil_pkg::bil_status_t status_o
);
  localparam int PH = bil_pkg::RESET_PHASE_CYC;
  logic [15:0] cyc;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Cycles since reset release; it saturates so a long run never wraps back into the phase.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cyc <= 16'h0000;
    else if (cyc != 16'hFFFF)
      cyc <= cyc + 16'h0001;
  end
  a_reset_pulls_down: assert property (disable iff (1'b0)
    !rst_b_i |-> pull_down_en_o && qpins_o.sel_b && qpins_o.doe == 4'h0) else $error("pins not parked in reset");
  a_phase_quiet: assert property (cyc < 16'(PH - 2) |-> qpins_o.sel_b && !status_o.done)
    else $error("boot began inside the reset phase");
  a_boot_begins: assert property (cyc == 16'(PH + 6) |-> status_o.done || !qpins_o.sel_b)
    else $error("boot did not begin after the reset phase");
  a_sclk_idle_low: assert property (qpins_o.sel_b |-> !qpins_o.sclk)
    else $error("serial clock high while deselected");
  a_data_stable_high: assert property (qpins_o.sclk && $past(qpins_o.sclk) |-> $stable(qpins_o.dout))
    else $error("data out changed while serial clock high");
  a_sclk_high_time: assert property ($rose(qpins_o.sclk) |-> qpins_o.sclk[*4] ##1 !qpins_o.sclk)
    else $error("serial clock high time is not four cycles");
  a_single_line_cmd: assert property (!qpins_o.sel_b |-> qpins_o.doe == 4'h0 || qpins_o.doe == 4'h1)
    else $error("unexpected data line enables");
  a_run_means_pass: assert property (run_o |-> status_o.done && !status_o.fail)
    else $error("program started without a passing boot");
  a_run_stands: assert property (run_o |=> run_o && !ram_wr_o.we)
    else $error("start dropped or RAM written after start");
  a_link_zero_chan: assert property (status_o.link_zero_en |-> status_o.tile0_src == bil_pkg::BIL_SRC_CHAN)
    else $error("link zero enabled without channel boot");
  cover property ($rose(run_o));
  cover property ($rose(status_o.fail));
  cover property ($rose(status_o.link_zero_en));
endmodule : bil_loader_sva
bind bil_loader bil_loader_sva u_bil_loader_sva (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .qpins_o(qpins_o),
  .pull_down_en_o(pull_down_en_o), .ram_wr_o(ram_wr_o), .run_o(run_o), .status_o(status_o));
`default_nettype wire

// >>> test/testbench.sv
/*
  Self-checking bench for the boot image loader with a flash model.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
  // Clock starts high so the reset fall comes before any rising edge meets unknown state.
  logic                 ref_clk = 1'b1;
  logic                 rst_b = 1'b1;
  logic [2:0]           strap = 3'h0;
  logic [31:0]          sec = 32'h0;
  logic [3:0]           fdata;
  logic [31:0]          cmd;
  logic [31:0]          ram_img [0:15];
  wire logic [3:0]      qline;
  bil_pkg::bil_qpins_t  qpins;
  logic                 pull_down_en;
  bil_pkg::bil_ram_wr_t wr;
  logic                 run;
  bil_pkg::bil_status_t status;
  int                   bad_count = 0;
  int                   compares = 0;
  int                   cycles = 0;
  // Each data line carries whichever party enables it.
  assign qline = (qpins.doe & qpins.dout) | (~qpins.doe & fdata);
  always #5 ref_clk = ~ref_clk;
  // Cut a hang short; the whole run needs about 20000 cycles.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  // Keep a copy of every word the loader writes.
  always @(posedge ref_clk)
  begin
    if (wr.we === 1'b1)
      ram_img[wr.addr[3:0]] <= wr.data;
  end
  bil_loader u_bil_loader (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .boot_select_bit0_i(strap[0]),
    .boot_select_bit1_i(strap[1]), .boot_select_bit2_i(strap[2]), .security_reg_i(sec), .quad_data_lines_i(qline),
    .qpins_o(qpins), .pull_down_en_o(pull_down_en), .ram_wr_o(wr), .run_o(run), .status_o(status));
  bil_flash_model u_bil_flash_model (.sel_b_i(qpins.sel_b), .sclk_i(qpins.sclk), .line_i(qline), .data_o(fdata),
    .cmd_o(cmd));
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ bil_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_step
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic do_boot(input logic [2:0] s, input logic [31:0] sr, output int n);
    @(negedge ref_clk);
    rst_b = 1'b0;
    strap = s;
    sec = sr;
    repeat (2) @(negedge ref_clk);
    `CHK(pull_down_en, 1'b1)
    foreach (ram_img[i])
      ram_img[i] = 32'h0;
    rst_b = 1'b1;
    n = 0;
    while (status.done !== 1'b1 && n < 9000)
    begin
      @(negedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
  endtask : do_boot
  task automatic test_straps;
    logic [2:0] s [0:4] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    bil_pkg::bil_src_t t0 [0:4] = '{bil_pkg::BIL_SRC_SPIM, bil_pkg::BIL_SRC_SPIS, bil_pkg::BIL_SRC_SPIS,
      bil_pkg::BIL_SRC_CHAN, bil_pkg::BIL_SRC_OTP};
    bil_pkg::bil_src_t t1 [0:3] = '{bil_pkg::BIL_SRC_CHAN, bil_pkg::BIL_SRC_CHAN, bil_pkg::BIL_SRC_SPIS,
      bil_pkg::BIL_SRC_CHAN};
    int n;
    for (int i = 0; i < 5; i++)
    begin
      do_boot(s[i], (i == 4) ? 32'h20 : 32'h3, n);
      `CHK(n >= bil_pkg::RESET_PHASE_CYC, 1'b1)
      `CHK(n <= bil_pkg::RESET_PHASE_CYC + 10, 1'b1)
      `CHK(status.tile0_src, t0[i])
      if (i < 4)
        `CHK(status.tile1_src, t1[i])
      `CHK(status.link_zero_en, i == 3)
      `CHK(run, 1'b0)
      `CHK(pull_down_en, 1'b0)
    end
    $display("test straps done");
  endtask : test_straps
  task automatic test_qspi(input int len, input int mode);
    logic [31:0] crc;
    logic [31:0] word;
    int n;
    crc = bil_pkg::CRC_PRESET;
    for (int i = 0; i < 4 + 4 * len; i++)
    begin
      u_bil_flash_model.mem[i] = (i < 4) ? 8'(len >> (8 * i)) : 8'(8'h5A + 8'h13 * i);
      crc = crc_step(crc, u_bil_flash_model.mem[i]);
    end
    word = (mode == 1) ? bil_pkg::NO_CRC_WORD : (~crc ^ ((mode == 2) ? 32'h1 : 32'h0));
    for (int i = 0; i < 4; i++)
      u_bil_flash_model.mem[4 + 4 * len + i] = word[8 * i +: 8];
    do_boot(3'h0, 32'h1, n);
    `CHK(cmd, {bil_pkg::FLASH_READ_CMD, bil_pkg::FLASH_START_ADDR})
    `CHK(status.fail, mode == 2)
    `CHK(run, mode != 2)
    for (int k = 0; k < len; k++)
      `CHK(ram_img[k], {u_bil_flash_model.mem[4 * k + 7], u_bil_flash_model.mem[4 * k + 6],
        u_bil_flash_model.mem[4 * k + 5], u_bil_flash_model.mem[4 * k + 4]})
    $display("test qspi done");
  endtask : test_qspi
  // Main sequence.
  initial
  begin
    test_straps();
    test_qspi(2, 0);
    test_qspi(0, 0);
    test_qspi(3, 1);
    test_qspi(1, 2);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
